// ### rtl/ths_pkg.sv
package ths_pkg;

    // Bus word offsets
    localparam logic [7:0] OFS_CTRL   = 8'h00;
    localparam logic [7:0] OFS_DELAY  = 8'h04;
    localparam logic [7:0] OFS_PRESET = 8'h08;
    localparam logic [7:0] OFS_HYST   = 8'h0C;
    localparam logic [7:0] OFS_MEAS   = 8'h10;
    localparam logic [7:0] OFS_EXT16  = 8'h14;
    localparam logic [7:0] OFS_EXT8   = 8'h18;
    localparam logic [7:0] OFS_TEACH  = 8'h1C;
    localparam logic [7:0] OFS_INIT   = 8'h20;
    localparam logic [7:0] OFS_STATUS = 8'h24;

    // Control field positions
    localparam int CTRL_DIR      = 0;
    localparam int CTRL_TRIG_LO  = 1;
    localparam int CTRL_REL_LO   = 3;
    localparam int CTRL_EXT_LO   = 5;
    localparam int CTRL_SOC      = 7;
    localparam int CTRL_BINARY   = 8;
    localparam int CTRL_TEACH_RST = 9;
    localparam int CTRL_CYC_LO   = 16;
    localparam int DELAY_OFF_LO  = 4;

    // Status field positions
    localparam int STAT_INT      = 16;
    localparam int STAT_DLY      = 17;
    localparam int STAT_RUN      = 18;
    localparam int STAT_MUTE     = 19;
    localparam int STAT_TAUGHT   = 20;

    // Values after reset
    localparam logic [15:0] RST_PRESET = 16'h8000;
    localparam logic [15:0] RST_HYST   = 16'h0100;
    localparam logic [6:0]  RST_CYC    = 7'h00;

    // Timing
    localparam int ONE_SEC_NS       = 1_000_000_000;
    localparam int CLK_PERIOD_NS    = 25;
    localparam int TICK_CYCLES_DFLT = ONE_SEC_NS / CLK_PERIOD_NS;
    localparam logic [3:0] CYC_UNIT_S = 4'hA;
    localparam logic [6:0] CYC_MAX    = 7'h78;

    typedef enum logic [1:0] {
        RESP_OFF  = 2'h0,
        RESP_ON   = 2'h1,
        RESP_NONE = 2'h2
    } ths_resp_t;

    typedef enum logic [1:0] {
        EXT_NONE  = 2'h0,
        EXT_16    = 2'h1,
        EXT_8     = 2'h2,
        EXT_TEACH = 2'h3
    } ths_ext_t;

    typedef enum logic [1:0] {
        TMR_IDLE = 2'b00,
        TMR_RUN  = 2'b01,
        TMR_FIRE = 2'b11
    } ths_tmr_t;

    // Delay list in seconds; index 0 means no delay
    function automatic logic [11:0] ths_delay_secs(input logic [3:0] idx);
        case (idx)
            4'h0:    ths_delay_secs = 12'h000;
            4'h1:    ths_delay_secs = 12'h001;
            4'h2:    ths_delay_secs = 12'h002;
            4'h3:    ths_delay_secs = 12'h003;
            4'h4:    ths_delay_secs = 12'h005;
            4'h5:    ths_delay_secs = 12'h00A;
            4'h6:    ths_delay_secs = 12'h00F;
            4'h7:    ths_delay_secs = 12'h014;
            4'h8:    ths_delay_secs = 12'h01E;
            4'h9:    ths_delay_secs = 12'h03C;
            4'hA:    ths_delay_secs = 12'h078;
            4'hB:    ths_delay_secs = 12'h12C;
            4'hC:    ths_delay_secs = 12'h258;
            4'hD:    ths_delay_secs = 12'h4B0;
            4'hE:    ths_delay_secs = 12'h708;
            default: ths_delay_secs = 12'hE10;
        endcase
    endfunction

endpackage

// ### rtl/ths_switch.sv
// Notes on behaviour
// - Rising: above level sets, below level-hyst releases
// - Falling: below level sets, above level+hyst releases
// - No-telegram response mutes change and cyclic sends
// - External level from 16-bit or 8-bit object
// - External level replaces preset until rewritten
// - Init restores preset, discarding external level
// - External entry refused on binary precipitation channel
// - Teach value 1 copies last sample
// - Teach value 0 is ignored
// - Taught level survives; init clears only if enabled
// - No teach on binary precipitation channel
// - Rise uses on-delay, fall uses off-delay
// - Zero delay: delayed state follows at once
// - Delay runs a timer; adopt and send on expiry
// - Change back stops timer, nothing sent
// - Cyclic sends use the delayed state
// - Separate on/off delays from 1 s list
// - Send on each delayed state edge when send-on-change is set and its response is not none
// - Recurring event resends its value
// - Cycle setting 0..120 times 10 s, 0 off
//
// The implementer's own choices: the register addresses and the AHB-Lite slave port.
`timescale 1ns/100ps
module ths_switch #(
    parameter int TICK_CYCLES = ths_pkg::TICK_CYCLES_DFLT
) (
    // Clock and reset
    input  wire logic        mclk,
    input  wire logic        resetn,
    // AHB-Lite slave
    input  wire logic        hsel,
    input  wire logic [31:0] haddr,
    input  wire logic [1:0]  htrans,
    input  wire logic        hwrite,
    input  wire logic [2:0]  hsize,
    input  wire logic [31:0] hwdata,
    input  wire logic        hready,
    output logic             hreadyout,
    output logic             hresp,
    output logic [31:0]      hrdata,
    // Switching telegram
    output logic             tx_strobe,
    output logic             tx_value,
    output logic             switch_state
);
    import ths_pkg::*;

    localparam int TW = $clog2(TICK_CYCLES + 1);

    typedef struct packed {
        logic          a_wr;
        logic [7:0]    a_ofs;
        logic [31:0]   rdata;
        logic          dir;
        ths_resp_t     trig_resp;
        ths_resp_t     rel_resp;
        ths_ext_t      ext_mode;
        logic          send_chg;
        logic          binary;
        logic          teach_rst;
        logic [6:0]    cyc_set;
        logic [3:0]    on_idx;
        logic [3:0]    off_idx;
        logic [15:0]   preset;
        logic [15:0]   hyst;
        logic [15:0]   meas;
        logic [15:0]   threshold_level;
        logic          taught;
        logic          int_st;
        logic          dly_st;
        ths_tmr_t      tmr;
        logic [11:0]   secs;
        logic [TW-1:0] tick;
        logic [TW-1:0] dtick;
        logic [10:0]   cyc_cnt;
        logic          tx_strobe;
        logic          tx_value;
    } ths_state_t;

    ths_state_t s_ff;
    ths_state_t nxt_s;

    // Compare one sample against level and hysteresis
    function automatic logic ths_compare(input logic dir, input logic cur,
                                         input logic [15:0] m, input logic [15:0] lvl,
                                         input logic [15:0] hy);
        logic [16:0] hi;
        logic [16:0] lo;
        logic        res;
        hi  = {1'b0, lvl} + {1'b0, hy};
        lo  = {1'b0, lvl} - {1'b0, hy};
        res = cur;
        if (!dir) begin
            if (m > lvl) begin
                res = 1'b1;
            end else if (!lo[16] && ({1'b0, m} < lo)) begin
                res = 1'b0;
            end
        end else begin
            if (m < lvl) begin
                res = 1'b1;
            end else if ({1'b0, m} > hi) begin
                res = 1'b0;
            end
        end
        return res;
    endfunction

    // Response configured for a delayed state
    function automatic ths_resp_t ths_resp_for(input logic st, input ths_resp_t trig,
                                               input ths_resp_t rel);
        return st ? trig : rel;
    endfunction

    // Muted when the held delayed state has no telegram
    function automatic logic resp_mute(input ths_state_t st);
        return ths_resp_for(st.dly_st, st.trig_resp, st.rel_resp) == RESP_NONE;
    endfunction

    // Last cycle of one second
    function automatic logic ths_tick_end(input logic [TW-1:0] t);
        return t == TW'(TICK_CYCLES - 1);
    endfunction

    // Telegram value of a response
    function automatic logic ths_resp_on(input ths_resp_t r);
        return r == RESP_ON;
    endfunction

    always_comb begin
        logic      addr_ok;
        logic      dwr;
        logic      new_sample;
        logic      new_int;
        logic      sec_tick;
        logic      dly_chg;
        logic      ext_ok;
        logic [3:0] sel_idx;
        logic [10:0] cyc_len;
        ths_resp_t resp;
        addr_ok    = 1'b0;
        dwr        = 1'b0;
        new_sample = 1'b0;
        new_int    = s_ff.int_st;
        sec_tick   = 1'b0;
        dly_chg    = 1'b0;
        ext_ok     = 1'b0;
        sel_idx    = 4'h0;
        cyc_len    = 11'h000;
        resp       = RESP_NONE;
        nxt_s      = s_ff;
        nxt_s.tx_strobe = 1'b0;

        // Address phase capture and read data
        addr_ok = hsel && hready && htrans[1];
        if (hready) begin
            nxt_s.a_wr  = addr_ok && hwrite;
            nxt_s.a_ofs = haddr[7:0];
        end
        if (addr_ok && !hwrite) begin
            case (haddr[7:0])
                OFS_CTRL:   nxt_s.rdata = {9'h000, s_ff.cyc_set, 6'h00, s_ff.teach_rst,
                                           s_ff.binary, s_ff.send_chg, s_ff.ext_mode,
                                           s_ff.rel_resp, s_ff.trig_resp, s_ff.dir};
                OFS_DELAY:  nxt_s.rdata = {24'h000000, s_ff.off_idx, s_ff.on_idx};
                OFS_PRESET: nxt_s.rdata = {16'h0000, s_ff.preset};
                OFS_HYST:   nxt_s.rdata = {16'h0000, s_ff.hyst};
                OFS_MEAS:   nxt_s.rdata = {16'h0000, s_ff.meas};
                OFS_STATUS: nxt_s.rdata = {11'h000, s_ff.taught,
                                           (resp_mute(s_ff)), s_ff.tmr == TMR_RUN,
                                           s_ff.dly_st, s_ff.int_st, s_ff.threshold_level};
                default:    nxt_s.rdata = 32'h00000000;
            endcase
        end

        // Data phase writes
        dwr = s_ff.a_wr;
        // external objects absent on binary channel
        ext_ok = !s_ff.binary;
        if (dwr) begin
            case (s_ff.a_ofs)
                OFS_CTRL: begin
                    nxt_s.dir       = hwdata[CTRL_DIR];
                    nxt_s.trig_resp = ths_resp_t'(hwdata[CTRL_TRIG_LO +: 2]);
                    nxt_s.rel_resp  = ths_resp_t'(hwdata[CTRL_REL_LO +: 2]);
                    nxt_s.ext_mode  = ths_ext_t'(hwdata[CTRL_EXT_LO +: 2]);
                    nxt_s.send_chg  = hwdata[CTRL_SOC];
                    nxt_s.binary    = hwdata[CTRL_BINARY];
                    nxt_s.teach_rst = hwdata[CTRL_TEACH_RST];
                    if (hwdata[CTRL_CYC_LO +: 7] > CYC_MAX) begin
                        nxt_s.cyc_set = CYC_MAX;
                    end else begin
                        nxt_s.cyc_set = hwdata[CTRL_CYC_LO +: 7];
                    end
                end
                OFS_DELAY: begin
                    nxt_s.on_idx  = hwdata[3:0];
                    nxt_s.off_idx = hwdata[DELAY_OFF_LO +: 4];
                end
                OFS_PRESET: nxt_s.preset = hwdata[15:0];
                OFS_HYST:   nxt_s.hyst   = hwdata[15:0];
                // New sample triggers compare
                OFS_MEAS: begin
                    nxt_s.meas = hwdata[15:0];
                    new_sample = 1'b1;
                end
                OFS_EXT16: begin
                    if (ext_ok && s_ff.ext_mode == EXT_16) begin
                        nxt_s.threshold_level = hwdata[15:0];
                        nxt_s.taught          = 1'b0;
                    end
                end
                // 8-bit percentage scaled to full range
                OFS_EXT8: begin
                    if (ext_ok && s_ff.ext_mode == EXT_8) begin
                        nxt_s.threshold_level = {hwdata[7:0], hwdata[7:0]};
                        nxt_s.taught          = 1'b0;
                    end
                end
                OFS_TEACH: begin
                    if (ext_ok && s_ff.ext_mode == EXT_TEACH && hwdata[0]) begin
                        nxt_s.threshold_level = s_ff.meas;
                        nxt_s.taught          = 1'b1;
                    end
                end
                OFS_INIT: begin
                    if (hwdata[0] && (!s_ff.taught || s_ff.teach_rst)) begin
                        nxt_s.threshold_level = s_ff.preset;
                        nxt_s.taught          = 1'b0;
                    end
                end
                default: ;
            endcase
        end

        // One-second prescaler
        if (ths_tick_end(s_ff.tick)) begin
            nxt_s.tick = '0;
            sec_tick   = 1'b1;
        end else begin
            nxt_s.tick = s_ff.tick + TW'(1);
        end

        if (new_sample) begin
            if (s_ff.binary) begin
                new_int = hwdata[0];
            end else begin
                new_int = ths_compare(s_ff.dir, s_ff.int_st, hwdata[15:0],
                                      s_ff.threshold_level, s_ff.hyst);
            end
        end
        nxt_s.int_st = new_int;

        // Delay timer
        if (new_int != s_ff.int_st) begin
            if (new_int == s_ff.dly_st) begin
                nxt_s.tmr   = TMR_IDLE;
                nxt_s.secs  = 12'h000;
                nxt_s.dtick = '0;
            end else begin
                // direction picks on or off delay
                sel_idx = new_int ? s_ff.on_idx : s_ff.off_idx;
                if (ths_delay_secs(sel_idx) == 12'h000) begin
                    nxt_s.dly_st = new_int;
                    nxt_s.tmr    = TMR_IDLE;
                    dly_chg      = 1'b1;
                end else begin
                    nxt_s.tmr   = TMR_RUN;
                    nxt_s.secs  = ths_delay_secs(sel_idx);
                    nxt_s.dtick = '0;
                end
            end
        end else begin
            case (s_ff.tmr)
                TMR_IDLE: begin
                    nxt_s.dtick = '0;
                end
                TMR_RUN: begin
                    if (ths_tick_end(s_ff.dtick)) begin
                        nxt_s.dtick = '0;
                        if (s_ff.secs == 12'h001) begin
                            nxt_s.tmr = TMR_FIRE;
                        end else begin
                            nxt_s.secs = s_ff.secs - 12'h001;
                        end
                    end else begin
                        nxt_s.dtick = s_ff.dtick + TW'(1);
                    end
                end
                TMR_FIRE: begin
                    nxt_s.dly_st = s_ff.int_st;
                    nxt_s.tmr    = TMR_IDLE;
                    nxt_s.secs   = 12'h000;
                    nxt_s.dtick  = '0;
                    dly_chg      = 1'b1;
                end
                default: nxt_s.tmr = TMR_IDLE;
            endcase
        end

        resp = ths_resp_for(nxt_s.dly_st, s_ff.trig_resp, s_ff.rel_resp);
        if (dly_chg && s_ff.send_chg && resp != RESP_NONE) begin
            nxt_s.tx_strobe = 1'b1;
            nxt_s.tx_value  = ths_resp_on(resp);
        end

        cyc_len = 11'(s_ff.cyc_set) * 11'(CYC_UNIT_S);
        if (s_ff.cyc_set == 7'h00) begin
            nxt_s.cyc_cnt = 11'h000;
        end else if (sec_tick) begin
            if (s_ff.cyc_cnt + 11'h001 >= cyc_len) begin
                nxt_s.cyc_cnt = 11'h000;
                resp = ths_resp_for(nxt_s.dly_st, s_ff.trig_resp, s_ff.rel_resp);
                if (resp != RESP_NONE && !nxt_s.tx_strobe) begin
                    nxt_s.tx_strobe = 1'b1;
                    nxt_s.tx_value  = ths_resp_on(resp);
                end
            end else begin
                nxt_s.cyc_cnt = s_ff.cyc_cnt + 11'h001;
            end
        end
    end

    always_ff @(posedge mclk or negedge resetn) begin
        if (!resetn) begin
            s_ff                 <= '0;
            s_ff.trig_resp       <= RESP_ON;
            s_ff.rel_resp        <= RESP_OFF;
            s_ff.ext_mode        <= EXT_NONE;
            s_ff.cyc_set         <= RST_CYC;
            s_ff.preset          <= RST_PRESET;
            s_ff.hyst            <= RST_HYST;
            s_ff.threshold_level <= RST_PRESET;
            s_ff.tmr             <= TMR_IDLE;
        end else begin
            s_ff <= nxt_s;
        end
    end

    assign hreadyout    = 1'b1;
    assign hresp        = 1'b0;
    assign hrdata       = s_ff.rdata;
    assign tx_strobe    = s_ff.tx_strobe;
    assign tx_value     = s_ff.tx_value;
    assign switch_state = s_ff.dly_st;

endmodule

// ### tb/ths_bus_peer.sv
`timescale 1ns/100ps
module ths_bus_peer (
    // Clock and reset
    input  wire logic        mclk,
    input  wire logic        resetn,
    // Telegram in
    input  wire logic        tx_strobe,
    input  wire logic        tx_value,
    // Received log
    output logic      [15:0] rx_count,
    output logic             rx_last
);
    always_ff @(posedge mclk or negedge resetn) begin
        if (!resetn) begin
            rx_count <= 16'h0000;
            rx_last  <= 1'b0;
        end else if (tx_strobe) begin
            rx_count <= rx_count + 16'h0001;
            rx_last  <= tx_value;
        end
    end
endmodule

// ### tb/ths_switch_assertions.sv
`timescale 1ns/100ps
module ths_switch_chk (
    // Clock and reset
    input  wire logic        mclk,
    input  wire logic        resetn,
    // Bus
    input  wire logic        hsel,
    input  wire logic [31:0] haddr,
    input  wire logic [1:0]  htrans,
    input  wire logic        hwrite,
    input  wire logic [31:0] hwdata,
    input  wire logic        hready,
    // Telegram
    input  wire logic        tx_strobe,
    input  wire logic        tx_value,
    input  wire logic        switch_state
);
    import ths_pkg::*;
    logic        cwr_ff;
    logic [31:0] ctrl_ff;
    logic [1:0]  trg;
    logic [1:0]  rel;
    logic        soc;
    logic [6:0]  cyc;
    assign trg = ctrl_ff[2:1];
    assign rel = ctrl_ff[4:3];
    assign soc = ctrl_ff[7];
    assign cyc = ctrl_ff[22:16];
    always_ff @(posedge mclk or negedge resetn) begin
        if (!resetn) begin
            cwr_ff  <= 1'b0;
            ctrl_ff <= 32'h0000_0002;
        end else begin
            cwr_ff <= hsel && hready && htrans[1] && hwrite && haddr[7:0] == OFS_CTRL;
            if (cwr_ff) begin
                ctrl_ff <= hwdata;
            end
        end
    end
    default clocking @(posedge mclk); endclocking
    default disable iff (!resetn);
    a_strobe_pulse: assert property (tx_strobe |=> !tx_strobe)
        else $error("strobe too long");
    a_value_holds: assert property ($changed(tx_value) |-> tx_strobe)
        else $error("value moved without strobe");
    a_rise_sends: assert property ($rose(switch_state) && soc && trg != RESP_NONE
        && $stable(ctrl_ff) |-> tx_strobe && tx_value == (trg == RESP_ON))
        else $error("no send on rise");
    a_fall_sends: assert property ($fell(switch_state) && soc && rel != RESP_NONE
        && $stable(ctrl_ff) |-> tx_strobe && tx_value == (rel == RESP_ON))
        else $error("no send on fall");
    a_value_resp: assert property (tx_strobe && $stable(ctrl_ff) |->
        tx_value == ((switch_state ? trg : rel) == RESP_ON))
        else $error("wrong telegram value");
    a_mute_quiet: assert property (((switch_state ? trg : rel) == RESP_NONE)
        && $stable(switch_state) && $stable(ctrl_ff) |-> !tx_strobe)
        else $error("send while muted");
    a_cyc_off: assert property (!soc && cyc == 7'h00 && $stable(ctrl_ff) |-> !tx_strobe)
        else $error("send with sending off");
    a_send_edge: assert property (tx_strobe && cyc == 7'h00 && $stable(ctrl_ff) |->
        switch_state != $past(switch_state))
        else $error("send without state edge");
    c_rise: cover property ($rose(switch_state) && tx_strobe);
    c_fall: cover property ($fell(switch_state) && tx_strobe);
    c_cyclic: cover property (cyc != 7'h00 && tx_strobe && $stable(switch_state));
endmodule
bind ths_switch ths_switch_chk u_chk (.mclk(mclk), .resetn(resetn), .hsel(hsel),
    .haddr(haddr), .htrans(htrans), .hwrite(hwrite), .hwdata(hwdata), .hready(hready),
    .tx_strobe(tx_strobe), .tx_value(tx_value), .switch_state(switch_state));

// ### tb/tb_top.sv
`timescale 1ns/100ps
module tb_top;
    import ths_pkg::*;
    logic        mclk, resetn, hsel, hwrite, hreadyout, hresp;
    logic        tx_strobe, tx_value, switch_state, rx_last;
    logic [31:0] haddr, hwdata, hrdata, rd;
    logic [1:0]  htrans;
    logic [2:0]  hsize;
    logic [15:0] rx_count, n0;
    int          bad_count, checks, cyc_n;

    ths_switch #(.TICK_CYCLES(20)) dut (.mclk(mclk), .resetn(resetn), .hsel(hsel),
        .haddr(haddr), .htrans(htrans), .hwrite(hwrite), .hsize(hsize), .hwdata(hwdata),
        .hready(hreadyout), .hreadyout(hreadyout), .hresp(hresp), .hrdata(hrdata),
        .tx_strobe(tx_strobe), .tx_value(tx_value), .switch_state(switch_state));
    ths_bus_peer peer (.mclk(mclk), .resetn(resetn), .tx_strobe(tx_strobe),
        .tx_value(tx_value), .rx_count(rx_count), .rx_last(rx_last));

    initial begin
        mclk = 1'b0;
        forever #12.5 mclk = ~mclk;
    end

    task automatic summarize();
        if (bad_count == 0 && checks > 0) begin
            $display("Finished cleanly");
        end else begin
            $display("Finished with errors");
        end
        $finish;
    endtask

    always @(posedge mclk) begin
        cyc_n <= cyc_n + 1;
        if (cyc_n == 20000) begin
            bad_count++;
            summarize();
        end
    end

    task automatic chk(input string nm, input logic [31:0] e, input logic [31:0] g);
        checks++;
        if (g !== e) begin
            bad_count++;
            $display("unexpected %s: expected %h seen %h", nm, e, g);
        end
    endtask

    task automatic xfer(input logic w, input logic [7:0] a, input logic [31:0] d);
        hsel   <= 1'b1;
        haddr  <= {24'h0, a};
        hwrite <= w;
        htrans <= 2'h2;
        @(posedge mclk);
        while (hreadyout !== 1'b1) @(posedge mclk);
        htrans <= 2'h0;
        hwdata <= d;
        @(posedge mclk);
        while (hreadyout !== 1'b1) @(posedge mclk);
        rd = hrdata;
        chk("hresp", 32'h0, {31'h0, hresp});
    endtask

    task automatic wr(input logic [7:0] a, input logic [31:0] d);
        xfer(1'b1, a, d);
    endtask

    task automatic rchk(input string nm, input logic [7:0] a, input logic [31:0] e);
        xfer(1'b0, a, 32'h0);
        chk(nm, e, rd);
    endtask

    task automatic lchk(input logic [15:0] e);
        xfer(1'b0, OFS_STATUS, 32'h0);
        chk("level", {16'h0, e}, {16'h0, rd[15:0]});
    endtask

    task automatic meas(input logic [15:0] m, input logic [15:0] dn, input logic s, v);
        n0 = rx_count;
        wr(OFS_MEAS, {16'h0, m});
        repeat (3) @(posedge mclk);
        chk("telegrams", {16'h0, dn}, {16'h0, rx_count - n0});
        chk("switch_state", {31'h0, s}, {31'h0, switch_state});
        if (dn != 16'h0) chk("tx_value", {31'h0, v}, {31'h0, rx_last});
    endtask

    task automatic wst(input logic v);
        for (int i = 0; i < 80 && switch_state !== v; i++) @(posedge mclk);
        repeat (2) @(posedge mclk);
        chk("delayed", {31'h0, v}, {31'h0, switch_state});
        chk("telegrams", 32'h1, {16'h0, rx_count - n0});
        chk("tx_value", {31'h0, v}, {31'h0, rx_last});
    endtask

    task automatic t_reset();
        rchk("ctrl", OFS_CTRL, 32'h0000_0002);
        rchk("preset", OFS_PRESET, {16'h0, RST_PRESET});
        rchk("hyst", OFS_HYST, {16'h0, RST_HYST});
        rchk("status", OFS_STATUS, {16'h0, RST_PRESET});
        rchk("unmapped", 8'h30, 32'h0);
    endtask

    task automatic t_rise();
        wr(OFS_CTRL, 32'h0000_0082);
        meas(16'h9000, 16'h1, 1'b1, 1'b1);
        meas(16'h7F00, 16'h0, 1'b1, 1'b1);
        meas(16'h7EFF, 16'h1, 1'b0, 1'b0);
        wr(OFS_CTRL, 32'h0000_0088);
        meas(16'h9000, 16'h1, 1'b1, 1'b0);
        meas(16'h7EFF, 16'h1, 1'b0, 1'b1);
    endtask

    task automatic t_fall();
        wr(OFS_CTRL, 32'h0000_0083);
        meas(16'h7000, 16'h1, 1'b1, 1'b1);
        meas(16'h8100, 16'h0, 1'b1, 1'b1);
        meas(16'h8101, 16'h1, 1'b0, 1'b0);
    endtask

    task automatic t_mute();
        wr(OFS_CTRL, 32'h0000_0092);
        meas(16'h9000, 16'h1, 1'b1, 1'b1);
        wr(OFS_CTRL, 32'h0001_0092);
        n0 = rx_count;
        repeat (230) @(posedge mclk);
        chk("cyclic", 32'h1, {16'h0, rx_count - n0});
        chk("cyclic value", 32'h1, {31'h0, rx_last});
        wr(OFS_CTRL, 32'h0000_0092);
        meas(16'h7000, 16'h0, 1'b0, 1'b0);
        wr(OFS_CTRL, 32'h0001_0092);
        n0 = rx_count;
        repeat (230) @(posedge mclk);
        chk("muted", 32'h0, {16'h0, rx_count - n0});
        wr(OFS_CTRL, 32'h0000_0092);
        meas(16'h9000, 16'h1, 1'b1, 1'b1);
    endtask

    task automatic t_delay();
        wr(OFS_CTRL, 32'h0000_0082);
        wr(OFS_DELAY, 32'h0000_0012);
        meas(16'h7000, 16'h0, 1'b1, 1'b1);
        meas(16'h9000, 16'h0, 1'b1, 1'b1);
        repeat (60) @(posedge mclk);
        meas(16'h7000, 16'h0, 1'b1, 1'b1);
        wst(1'b0);
        meas(16'h9000, 16'h0, 1'b0, 1'b0);
        repeat (15) @(posedge mclk);
        chk("on delay", 32'h0, {31'h0, switch_state});
        wst(1'b1);
        wr(OFS_DELAY, 32'h0);
    endtask

    task automatic t_ext();
        wr(OFS_CTRL, 32'h0000_00A2);
        wr(OFS_EXT16, 32'h0000_4000);
        lchk(16'h4000);
        wr(OFS_EXT8, 32'h0000_0020);
        lchk(16'h4000);
        wr(OFS_CTRL, 32'h0000_00C2);
        wr(OFS_EXT8, 32'h0000_0020);
        lchk(16'h2020);
        wr(OFS_CTRL, 32'h0000_01C2);
        wr(OFS_EXT8, 32'h0000_0010);
        lchk(16'h2020);
        wr(OFS_INIT, 32'h1);
        lchk(RST_PRESET);
    endtask

    task automatic t_teach();
        wr(OFS_CTRL, 32'h0000_00E2);
        wr(OFS_MEAS, 32'h0000_1234);
        wr(OFS_TEACH, 32'h0);
        lchk(RST_PRESET);
        wr(OFS_TEACH, 32'h1);
        lchk(16'h1234);
        chk("taught", 32'h1, {31'h0, rd[STAT_TAUGHT]});
        wr(OFS_INIT, 32'h1);
        lchk(16'h1234);
        wr(OFS_CTRL, 32'h0000_02E2);
        wr(OFS_INIT, 32'h1);
        lchk(RST_PRESET);
        wr(OFS_CTRL, 32'h0000_01E2);
        wr(OFS_TEACH, 32'h1);
        lchk(RST_PRESET);
    endtask

    initial begin
        resetn = 1'b0;
        hsel = 1'b0;
        haddr = 32'h0;
        htrans = 2'h0;
        hwrite = 1'b0;
        hsize = 3'h2;
        hwdata = 32'h0;
        bad_count = 0;
        checks = 0;
        cyc_n = 0;
        repeat (4) @(posedge mclk);
        resetn <= 1'b1;
        @(posedge mclk);
        t_reset();
        t_rise();
        t_fall();
        t_mute();
        t_delay();
        t_ext();
        t_teach();
        summarize();
    end
endmodule
